// [src/rclp_pkg.sv]
// Package for the reset cause and low power control block
// Summary of operation
// (R1) Pin toggle in stop starts stop recovery
// (R2) Wake pins filtered against short pulses
// (R3) Pin stop recovery shows stop only
// (R4) Short wake pulse may wake without interrupt
// (R5) Fault selection disables reset pin function
// (R6) Software writes 14h, 92h, then select bit
// (R7) Out-of-order select writes ignored, lock stays
// (R8) Software select write overrides option bit
// (R9) Select 0 reset input, 1 fault input
// (R10) Select resets to inverse of option bit
// (R11) Each event rewrites all cause flags
// (R12) Cause register flag layout at FF0H
// (R13) Pin reset external only; power-on only
// (R14) Watchdog reset sets watchdog and external
// (R15) Debugger reset sets power-on and external
// (R16) Fault reset sets external and fault
// (R17) Watchdog stop recovery sets stop, watchdog
// (R18) Simultaneous sources may merge flags
// (R19) Stop halts oscillators, clock and processor
// (R20) Stop keeps watchdog only if enabled
// (R21) Halt stops processor, clocks keep running
// (R22) Halt ends on listed events quickly
// (R23) Bit 4 disables brown-out detector
package rclp_pkg;
   localparam logic [11:0] RCLP_PWRCTL_ADDR = 12'hF80;
   localparam logic [11:0] RCLP_CAUSE_ADDR = 12'hFF0;
   localparam logic [7:0] RCLP_PWRCTL_RST = 8'h00;
   localparam logic [7:0] RCLP_UNLOCK1 = 8'h14;
   localparam logic [7:0] RCLP_UNLOCK2 = 8'h92;
   localparam int RCLP_POR_BIT = 7;
   localparam int RCLP_STOP_BIT = 6;
   localparam int RCLP_WDT_BIT = 5;
   localparam int RCLP_EXT_BIT = 4;
   localparam int RCLP_FAULT_BIT = 3;
   localparam int RCLP_SEL_BIT = 0;
   localparam int RCLP_BODIS_BIT = 4;
   localparam int RCLP_WAKE_W = 8;
   localparam int RCLP_CLK_MHZ = 50;
   localparam int RCLP_FILT_NS = 10;
   localparam int RCLP_FILT_CYC_RAW = (RCLP_FILT_NS * RCLP_CLK_MHZ + 999) / 1000;
   localparam int RCLP_FILT_CYC = (RCLP_FILT_CYC_RAW < 1) ? 1 : RCLP_FILT_CYC_RAW;
   localparam int RCLP_HALT_NS = 5000;
   localparam int RCLP_HALT_CYC = RCLP_HALT_NS * RCLP_CLK_MHZ / 1000;

   typedef struct packed {
      logic por;
      logic ext_pin;
      logic wdt;
      logic dbg;
      logic fault;
   } rclp_rst_src_t;

   typedef enum logic [2:0] {
      RCLP_RUN = 3'b001,
      RCLP_HALT = 3'b010,
      RCLP_STOP = 3'b100
   } rclp_mode_t;

   typedef enum logic [2:0] {
      RCLP_LK_IDLE = 3'b001,
      RCLP_LK_ONE = 3'b010,
      RCLP_LK_OPEN = 3'b100
   } rclp_lock_t;
endpackage

// [src/rclp_ctrl.sv]
// Reset cause recorder, pin select lock and low power mode control
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module rclp_ctrl
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire rclp_pkg::rclp_rst_src_t rst_src_i,
   input wire logic opt_sel_bit_i,
   input wire logic opt_bo_stop_i,
   input wire logic stop_instr_i,
   input wire logic halt_instr_i,
   input wire logic irq_i,
   input wire logic wdt_timeout_i,
   input wire logic wdt_stop_en_i,
   input wire logic [7:0] wake_en_i,
   input wire logic [7:0] wake_pin_i,
   input wire logic reset_fault_pin_i,
   output logic stop_o,
   output logic halt_o,
   output logic osc_en_o,
   output logic cpu_run_o,
   output logic wdt_run_o,
   output logic periph_idle_o,
   output logic stop_recovery_o,
   output logic ext_reset_req_o,
   output logic pwm_fault_zero_o,
   output logic brownout_en_o
);
   import rclp_pkg::*;

   // Cause flags span the power-on position down to the fault position
   localparam int FLAG_W = RCLP_POR_BIT - RCLP_FAULT_BIT + 1;

   // Synchronisers and glitch filter state for the asynchronous pins
   logic [7:0] wake_s1_reg;
   logic [7:0] wake_s2_reg;
   logic [7:0] wake_s3_reg;
   logic [7:0] wake_stable_reg;
   logic [7:0] filt_cnt_reg [RCLP_WAKE_W];
   logic pin_s1_reg;
   logic pin_s2_reg;

   // Register state and next values
   logic [FLAG_W-1:0] cause_reg;
   logic [FLAG_W-1:0] cause_next;
   logic sel_reg;
   logic sel_next;
   logic [7:0] pwr_reg;
   logic [7:0] pwr_next;
   rclp_mode_t mode_reg;
   rclp_mode_t mode_next;
   rclp_lock_t lock_reg;
   rclp_lock_t lock_next;
   logic init_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Packs the five cause flags into their register positions
   function automatic logic [FLAG_W-1:0] flag_word
   (
      input logic por_f,
      input logic stop_f,
      input logic wdt_f,
      input logic ext_f,
      input logic fault_f
   );
      logic [FLAG_W-1:0] f;
      f = '0;
      f[RCLP_POR_BIT - RCLP_FAULT_BIT] = por_f;
      f[RCLP_STOP_BIT - RCLP_FAULT_BIT] = stop_f;
      f[RCLP_WDT_BIT - RCLP_FAULT_BIT] = wdt_f;
      f[RCLP_EXT_BIT - RCLP_FAULT_BIT] = ext_f;
      f[0] = fault_f;
      return f;
   endfunction

   // Selects the register byte seen at an address; unmapped reads give zero
   function automatic logic [7:0] read_byte
   (
      input logic [11:0] addr,
      input logic [7:0] cause_b,
      input logic [7:0] pwr_b
   );
      logic [7:0] b;
      b = 8'h00;
      if (addr == RCLP_CAUSE_ADDR)
         b = cause_b;
      else if (addr == RCLP_PWRCTL_ADDR)
         b = pwr_b;
      return b;
   endfunction

   // One step of the unlock sequence; any wrong byte relocks
   function automatic rclp_lock_t lock_step
   (
      input rclp_lock_t cur,
      input logic [7:0] data
   );
      rclp_lock_t nxt;
      nxt = RCLP_LK_IDLE;
      unique case (cur)
         RCLP_LK_IDLE:
            if (data == RCLP_UNLOCK1)
               nxt = RCLP_LK_ONE; // see (R6)
         RCLP_LK_ONE:
            if (data == RCLP_UNLOCK2)
               nxt = RCLP_LK_OPEN; // see (R7)
         RCLP_LK_OPEN:
            nxt = RCLP_LK_IDLE;
         default:
            nxt = RCLP_LK_IDLE;
      endcase
      return nxt;
   endfunction

   // Bus decode
   wire logic bus_setup = psel_i && !penable_i;
   wire logic bus_access = psel_i && penable_i;
   wire logic bus_wr = bus_access && pwrite_i;
   wire logic rd_setup = bus_setup && !pwrite_i;
   wire logic hit_cause = paddr_i == RCLP_CAUSE_ADDR;
   wire logic hit_pwr = paddr_i == RCLP_PWRCTL_ADDR;
   wire logic hit_any = hit_cause || hit_pwr;
   wire logic [7:0] wbyte = pwdata_i[7:0];
   wire logic wr_cause = bus_wr && hit_cause;
   wire logic wr_pwr = bus_wr && hit_pwr;
   wire logic sel_write = wr_cause && lock_reg == RCLP_LK_OPEN;
   wire logic [7:0] bodis_mask = 8'h01 << RCLP_BODIS_BIT;

   // Mode decode
   wire logic in_run = mode_reg == RCLP_RUN;
   wire logic in_halt = mode_reg == RCLP_HALT;
   wire logic in_stop = mode_reg == RCLP_STOP;

   // Wake and reset sources
   wire logic [7:0] wake_change = (wake_stable_reg ^ wake_s3_reg) & wake_en_i;
   wire logic pin_wake = in_stop && (|wake_change); // see (R1) (R4)
   wire logic wdt_recovery = in_stop && wdt_timeout_i && wdt_stop_en_i;
   wire logic any_recovery = pin_wake || wdt_recovery;
   wire logic pin_rst = rst_src_i.ext_pin && !sel_reg; // see (R5) (R9)
   wire logic wdt_rst = rst_src_i.wdt && !in_stop;
   wire logic any_rst = rst_src_i.por || pin_rst || wdt_rst ||
      rst_src_i.dbg || rst_src_i.fault;

   // Flag patterns of each single source
   wire logic [FLAG_W-1:0] por_flags = flag_word(1'b1, 1'b0, 1'b0, 1'b0, 1'b0); // see (R13)
   wire logic [FLAG_W-1:0] pin_flags = flag_word(1'b0, 1'b0, 1'b0, 1'b1, 1'b0); // see (R13)
   wire logic [FLAG_W-1:0] wdt_flags = flag_word(1'b0, 1'b0, 1'b1, 1'b1, 1'b0); // see (R14)
   wire logic [FLAG_W-1:0] dbg_flags = flag_word(1'b1, 1'b0, 1'b0, 1'b1, 1'b0); // see (R15)
   wire logic [FLAG_W-1:0] fault_flags = flag_word(1'b0, 1'b0, 1'b0, 1'b1, 1'b1); // see (R16)
   wire logic [FLAG_W-1:0] wake_flags = flag_word(1'b0, 1'b1, 1'b0, 1'b0, 1'b0); // see (R3)
   wire logic [FLAG_W-1:0] rec_wdt_flags = flag_word(1'b0, 1'b1, 1'b1, 1'b0, 1'b0); // see (R17)
   wire logic [7:0] cause_byte = {cause_reg, 2'b00, sel_reg}; // see (R12)

   // Simultaneous sources of one kind merge their patterns; a reset overrides a recovery
   always_comb
   begin
      cause_next = cause_reg;
      if (any_rst) // see (R11) (R18)
      begin
         cause_next = '0;
         if (rst_src_i.por)
            cause_next = cause_next | por_flags; // see (R13)
         if (pin_rst)
            cause_next = cause_next | pin_flags; // see (R13)
         if (wdt_rst)
            cause_next = cause_next | wdt_flags; // see (R14)
         if (rst_src_i.dbg)
            cause_next = cause_next | dbg_flags; // see (R15)
         if (rst_src_i.fault)
            cause_next = cause_next | fault_flags; // see (R16)
      end
      else if (any_recovery) // see (R11)
      begin
         cause_next = '0;
         if (pin_wake)
            cause_next = cause_next | wake_flags; // see (R3)
         if (wdt_recovery)
            cause_next = cause_next | rec_wdt_flags; // see (R17)
      end
   end

   // Option value loads once after reset; an unlocked write overrides it
   always_comb
   begin
      sel_next = sel_reg;
      if (init_reg)
         sel_next = !opt_sel_bit_i; // see (R10)
      else if (sel_write)
         sel_next = wbyte[RCLP_SEL_BIT]; // see (R8)
   end

   // Only the detector disable bit is kept; other bits read zero
   always_comb
   begin
      pwr_next = pwr_reg;
      if (wr_pwr)
         pwr_next = wbyte & bodis_mask;
   end

   // Read data is captured in the setup cycle so it stands at the access edge
   always_comb
   begin
      rdata_next = rdata_reg;
      if (rd_setup)
         rdata_next = {24'h000000, read_byte(paddr_i, cause_byte, pwr_reg)};
   end

   // Every write to the cause address advances or relocks the sequence
   always_comb
   begin
      lock_next = lock_reg;
      if (wr_cause)
         lock_next = lock_step(lock_reg, wbyte);
   end

   // Halt exits on interrupt, watchdog or any reset; stop exits on recovery or any reset
   always_comb
   begin
      mode_next = mode_reg;
      unique case (mode_reg)
         RCLP_RUN:
         begin
            if (stop_instr_i)
               mode_next = RCLP_STOP; // see (R19)
            else if (halt_instr_i)
               mode_next = RCLP_HALT; // see (R21)
         end
         RCLP_HALT:
            if (irq_i || wdt_timeout_i || any_rst)
               mode_next = RCLP_RUN; // see (R22)
         RCLP_STOP:
            if (any_recovery || any_rst)
               mode_next = RCLP_RUN;
         default:
            mode_next = RCLP_RUN;
      endcase
   end

   // Pin synchronisers
   always_ff @(posedge clk_sys_i)
   begin
      wake_s1_reg <= wake_pin_i;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
      pin_s1_reg <= reset_fault_pin_i;
      pin_s2_reg <= pin_s1_reg;
   end

   // Glitch filter: a new level must persist for the filter count
   for (genvar g = 0; g < RCLP_WAKE_W; g++)
   begin : g_filt
      always_ff @(posedge clk_sys_i)
      begin
         if (srst_i)
            filt_cnt_reg[g] <= 8'h00;
         else if (wake_s3_reg[g] == wake_stable_reg[g])
            filt_cnt_reg[g] <= 8'h00;
         else if (filt_cnt_reg[g] < 8'(RCLP_FILT_CYC))
            filt_cnt_reg[g] <= filt_cnt_reg[g] + 8'h01;
      end
      always_ff @(posedge clk_sys_i)
      begin
         if (srst_i)
            wake_stable_reg[g] <= 1'b0;
         else if (init_reg || filt_cnt_reg[g] >= 8'(RCLP_FILT_CYC) - 8'h01) // see (R2)
            wake_stable_reg[g] <= wake_s3_reg[g];
      end
   end

   // First cycle after reset, used to load the option value
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         init_reg <= 1'b1;
      end
      else
      begin
         init_reg <= 1'b0;
      end
   end

   // Reset itself reads back as a power-on event
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         cause_reg <= por_flags;
      end
      else
      begin
         cause_reg <= cause_next;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         sel_reg <= 1'b0;
      end
      else
      begin
         sel_reg <= sel_next;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         pwr_reg <= RCLP_PWRCTL_RST;
      end
      else
      begin
         pwr_reg <= pwr_next;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         mode_reg <= RCLP_RUN;
      end
      else
      begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         lock_reg <= RCLP_LK_IDLE;
      end
      else
      begin
         lock_reg <= lock_next;
      end
   end

   // Read data holds until the next read setup
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   // Bus, mode and pin outputs
   assign prdata_o = rdata_reg;
   assign pready_o = 1'b1;
   assign pslverr_o = bus_access && !hit_any;
   assign stop_o = in_stop;
   assign halt_o = in_halt;
   assign osc_en_o = !in_stop; // see (R19)
   assign cpu_run_o = in_run; // see (R19) (R21)
   assign wdt_run_o = !in_stop || wdt_stop_en_i; // see (R20)
   assign periph_idle_o = in_stop; // see (R20)
   assign stop_recovery_o = any_recovery;
   assign ext_reset_req_o = pin_rst; // see (R5)
   assign pwm_fault_zero_o = sel_reg ? pin_s2_reg : 1'b1; // see (R9)
   assign brownout_en_o = !pwr_reg[RCLP_BODIS_BIT] &&
      (!in_stop || opt_bo_stop_i); // see (R23)
endmodule

// [bench/rclp_ctrl_props.sv]
// Port assertions for the reset cause and low power control block
`timescale 1ns/1ps
module rclp_ctrl_props
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic opt_bo_stop_i,
   input wire logic irq_i,
   input wire logic wdt_stop_en_i,
   input wire logic stop_o,
   input wire logic halt_o,
   input wire logic osc_en_o,
   input wire logic cpu_run_o,
   input wire logic wdt_run_o,
   input wire logic ext_reset_req_o,
   input wire logic pwm_fault_zero_o,
   input wire logic brownout_en_o,
   input wire logic periph_idle_o,
   input wire logic stop_recovery_o
);
   localparam int HALT_MAX = 250;
   wire acc = psel_i & penable_i;
   wire hit = (paddr_i == 12'hF80) || (paddr_i == 12'hFF0);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   AST_READY: assert property (acc |-> pready_o) else $error("no ready in access");
   AST_ERR: assert property (acc |-> pslverr_o == !hit) else $error("wrong slave error");
   AST_PIN: assert property (!(ext_reset_req_o && !pwm_fault_zero_o)) else $error("pin both");
   AST_STOP: assert property (stop_o |-> !osc_en_o && !cpu_run_o) else $error("stop runs");
   AST_WDT: assert property (stop_o && !wdt_stop_en_i |-> !wdt_run_o) else $error("wdt on");
   AST_HALT: assert property (halt_o |-> osc_en_o && !cpu_run_o) else $error("halt bad");
   AST_HEND: assert property (halt_o && irq_i |-> ##[1:HALT_MAX] !halt_o) else $error("halt");
   AST_BO: assert property (stop_o && !opt_bo_stop_i |-> !brownout_en_o) else $error("bo on");
   AST_IDLE: assert property (periph_idle_o == stop_o) else $error("idle mismatch");
   AST_REC: assert property (stop_recovery_o |-> stop_o ##1 !stop_o) else $error("no exit");
endmodule
bind rclp_ctrl rclp_ctrl_props rclp_ctrl_props_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
   .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .opt_bo_stop_i(opt_bo_stop_i), .irq_i(irq_i), .stop_o(stop_o),
   .wdt_stop_en_i(wdt_stop_en_i), .halt_o(halt_o), .osc_en_o(osc_en_o), .cpu_run_o(cpu_run_o),
   .wdt_run_o(wdt_run_o), .ext_reset_req_o(ext_reset_req_o), .brownout_en_o(brownout_en_o),
   .pwm_fault_zero_o(pwm_fault_zero_o), .periph_idle_o(periph_idle_o),
   .stop_recovery_o(stop_recovery_o));

// [bench/rclp_core_model.sv]
// Core model turning stop and halt requests into instruction pulses
`timescale 1ns/1ps
module rclp_core_model
(
   input wire logic clk_sys_i,
   input wire logic run_i,
   input wire logic go_stop_i,
   input wire logic go_halt_i,
   output logic stop_instr_o,
   output logic halt_instr_o
);
   // Instructions issue only while the processor runs
   always_ff @(posedge clk_sys_i)
   begin
      stop_instr_o <= go_stop_i & run_i;
      halt_instr_o <= go_halt_i & run_i;
   end
endmodule

// [bench/rclp_ctrl_tb.sv]
// Testbench for the reset cause and low power control block
`timescale 1ns/1ps
module rclp_ctrl_tb;
   import rclp_pkg::*;
   logic clk_sys_i = 0, srst_i = 1, ps = 0, pe = 0, pw = 0, irq = 0, wto = 0, wse = 0;
   logic gs = 0, gh = 0, si, hi, rdy, err, e, st, ha, run, pf, bo, pi, osel = 1;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, rd;
   logic [7:0] wen = 0, wpin = 0;
   rclp_rst_src_t src = '0;
   logic [12:0] tbl [5] = '{13'h0810, 13'h0430, 13'h0290, 13'h0118, 13'h1080};
   int bad_count = 0, n_checks = 0, cyc = 0, i;
   rclp_ctrl rclp_ctrl_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .paddr_i(pa), .psel_i(ps),
      .penable_i(pe), .pwrite_i(pw), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(err), .rst_src_i(src), .opt_sel_bit_i(osel), .opt_bo_stop_i(1'b0),
      .stop_instr_i(si), .halt_instr_i(hi), .irq_i(irq), .wdt_timeout_i(wto),
      .wdt_stop_en_i(wse), .wake_en_i(wen), .wake_pin_i(wpin), .reset_fault_pin_i(1'b0),
      .stop_o(st), .halt_o(ha), .osc_en_o(), .cpu_run_o(run), .wdt_run_o(),
      .periph_idle_o(pi), .stop_recovery_o(), .ext_reset_req_o(), .pwm_fault_zero_o(pf),
      .brownout_en_o(bo));
   rclp_core_model rclp_core_model_inst (.clk_sys_i(clk_sys_i), .run_i(run), .go_stop_i(gs),
      .go_halt_i(gh), .stop_instr_o(si), .halt_instr_o(hi));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         wrap_up;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Read data and error are taken at the edge where ready is seen high
   task xf(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      ps <= 1;
      pw <= w;
      pa <= a;
      pwd <= {24'h0, d};
      pe <= 0;
      @(posedge clk_sys_i);
      pe <= 1;
      do @(posedge clk_sys_i); while (rdy !== 1'b1);
      e = err;
      rd = prd;
      ps <= 0;
      pe <= 0;
   endtask
   task go(input logic h);
      @(posedge clk_sys_i);
      gh <= h; gs <= !h;
      @(posedge clk_sys_i);
      gh <= 0; gs <= 0;
      for (i = 0; i < 20 && (st | ha) !== 1'b1; i++) @(posedge clk_sys_i);
   endtask
   task lv;
      for (i = 0; i < 20 && (st | ha) === 1'b1; i++) @(posedge clk_sys_i);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 0;
      repeat (2) @(posedge clk_sys_i);
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h80);
      xf(0, 12'hF80, 0);
      chk(rd, 32'h0);
      xf(1, 12'hFF0, 8'h14);
      xf(1, 12'hFF0, 8'h92);
      xf(1, 12'hFF0, 8'h01);
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h81);
      chk({31'h0, pf}, 32'h0);
      xf(1, 12'hFF0, 8'h92);
      xf(1, 12'hFF0, 8'h14);
      xf(1, 12'hFF0, 8'h00);
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h81);
      xf(1, 12'hFF0, 8'h14);
      xf(1, 12'hFF0, 8'h92);
      xf(1, 12'hFF0, 8'h00);
      @(posedge clk_sys_i);
      chk({31'h0, pf}, 32'h1);
      for (i = 0; i < 5; i++)
      begin
         @(posedge clk_sys_i);
         src <= rclp_rst_src_t'(tbl[i][12:8]);
         @(posedge clk_sys_i);
         src <= '0;
         xf(0, 12'hFF0, 0);
         chk(rd, {24'h0, tbl[i][7:0]});
      end
      wen <= 8'h01;
      go(0);
      chk({31'h0, st}, 32'h1);
      chk({31'h0, pi}, 32'h1);
      wpin <= 8'h02;
      repeat (8) @(posedge clk_sys_i);
      chk({31'h0, st}, 32'h1);
      wpin <= 8'h03;
      lv;
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h40);
      wse <= 1;
      go(0);
      wto <= 1;
      @(posedge clk_sys_i);
      wto <= 0;
      lv;
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h60);
      go(1);
      chk({31'h0, ha}, 32'h1);
      irq <= 1;
      lv;
      irq <= 0;
      chk({31'h0, ha}, 32'h0);
      xf(1, 12'hF80, 8'hFF);
      xf(0, 12'hF80, 0);
      chk(rd, 32'h10);
      chk({31'h0, bo}, 32'h0);
      xf(1, 12'h100, 8'hFF);
      chk({31'h0, e}, 32'h1);
      xf(0, 12'h100, 0);
      chk(rd, 32'h0);
      osel <= 0;
      srst_i <= 1;
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 0;
      repeat (2) @(posedge clk_sys_i);
      xf(0, 12'hFF0, 0);
      chk(rd, 32'h81);
      wrap_up;
   end
endmodule
